// *** design/sss_regs.vh ***
// Register map, field positions and reset values of the serial status slice
`ifndef SSS_REGS_VH
`define SSS_REGS_VH

// Byte offsets of the word registers on the bus
`define SSS_OFF_CMP1      8'h00
`define SSS_OFF_STATUS    8'h04
`define SSS_OFF_IRQ_SET   8'h08
`define SSS_OFF_IRQ_CLR   8'h0C
`define SSS_OFF_MASK_RD   8'h10

// Status bit positions
`define SSS_BIT_TXHF      0
`define SSS_BIT_TXAS      1
`define SSS_BIT_TXDONE    2
`define SSS_BIT_TXBZ      3
`define SSS_BIT_RXHF      4
`define SSS_BIT_OVR       5
`define SSS_BIT_RXDONE    6
`define SSS_BIT_RXBZ      7
`define SSS_BIT_CMP0      8
`define SSS_BIT_CMP1      9
`define SSS_BIT_TX_FSYNC  10
`define SSS_BIT_RX_FSYNC  11
`define SSS_BIT_TX_ON     16
`define SSS_BIT_RX_ON     17

// Field widths
`define SSS_NSRC          12
`define SSS_CMP_W         16

// Reset values
`define SSS_MASK_RST      12'h000
`define SSS_CMP1_RST      16'h0000
`define SSS_FLAG_RST      1'h0
`define SSS_WORD_ZERO     32'h00000000
`define SSS_EVT_RST       4'h0
`define SSS_ADDR_RST      8'h00

// AHB transfer type upper bit (NONSEQ or SEQ)
`define SSS_HTRANS_ACT    1

`endif

// *** design/sss_top.v ***
// Status, compare-one and interrupt mask slice of a synchronous serial controller
// Contract
// RL1: Bit 0 shows transmit holding register free
// RL2: Bit 1 set when all data sent
// RL3: Bit 2 sticky on tx count zero
// RL4: Bit 3 high while both tx counts zero
// RL5: Bit 4 high while receive holding full
// RL6: Bit 5 overrun, cleared by status read
// RL7: Bit 6 sticky on rx count zero
// RL8: Bit 7 high while both rx counts zero
// RL9: Bit 8 compare zero, cleared by read
// RL10: Bit 9 compare one, cleared by read
// RL11: Bit 10 tx sync, cleared by read
// RL12: Bit 11 rx sync, cleared by read
// RL13: Bit 16 shows transmitter enabled
// RL14: Bit 17 shows receiver enabled
// RL15: Enable register ones set mask bits
// RL16: Disable register ones clear mask bits
// RL17: Compare one value bits 15:0 read-write
// RL18: Mask readable, one bit per source
// RL19: Interrupt high on any enabled flag
// RL20: Reset clears mask and event flags
//
// The placing of the registers and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sss_regs.vh"

// Bus timing in short:
// - Address phase taken on a rising edge with hsel, hready and htrans[1]
// - Read data registered there, stands for the whole data phase
// - Write data taken one edge later, in the data phase
// - hreadyout always high, no wait state ever inserted
// - hresp always low, every access ends OKAY
// - hsize not decoded, only whole-word accesses expected
// Flag timing in short:
// - Event strobes sampled on the edge where they stand
// - A sticky flag shows in a read whose address phase follows that edge
// - Read-to-clear flags drop on the address edge of a status read
// - A strobe in that same cycle keeps its flag, set beats clear
// - Interrupt registered, one cycle behind its cause

module sss_top
(
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,

    // AHB-Lite slave port
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,

    // Transmit path state
    input  wire        tx_holding_free,
    input  wire        tx_all_sent,
    input  wire        tx_enabled_state,

    // Transmit DMA counters
    input  wire        tx_cnt_hit_zero,
    input  wire        tx_cnt_is_zero,
    input  wire        tx_next_cnt_is_zero,
    input  wire        tx_cnt_written,

    // Receive path state
    input  wire        rx_holding_full,
    input  wire        rx_word_load,
    input  wire        rx_enabled_state,

    // Receive DMA counters
    input  wire        rx_cnt_hit_zero,
    input  wire        rx_cnt_is_zero,
    input  wire        rx_next_cnt_is_zero,
    input  wire        rx_cnt_written,

    // Compare and frame-sync events
    input  wire        compare_zero_hit,
    input  wire        compare_one,
    input  wire        tx_frame_sync_seen,
    input  wire        rx_frame_sync_seen,

    // Compare value and interrupt outputs
    output reg  [15:0] cmp1_value,
    output reg         irq
);

    // Offset match on the low address byte, used by read and write decode
    function addr_hit;
        input [7:0] a;
        input [7:0] off;
        begin
            addr_hit = (a[7:2] == off[7:2]);
        end
    endfunction

    // Address phase qualifiers
    wire        xfer_act;      // Valid transfer selected this cycle
    wire        rd_take;       // Read address phase accepted
    wire        wr_take;       // Write address phase accepted
    wire [7:0]  a_lo;          // Low byte of the address

    // Captured write address phase
    reg         wr_pend_q;     // A write data phase follows
    reg         wr_pend_d;
    reg  [7:0]  wr_addr_q;     // Address of that write
    reg  [7:0]  wr_addr_d;

    // Register state
    reg  [11:0] mask_q;        // Interrupt mask
    reg  [11:0] mask_d;
    reg  [15:0] cmp1_d;        // Next compare one value

    // Sticky event flags
    reg         tx_done_q;     // Tx count reached zero
    reg         tx_done_d;
    reg         rx_done_q;     // Rx count reached zero
    reg         rx_done_d;
    reg         ovr_q;         // Receive overrun
    reg         ovr_d;
    reg  [3:0]  evt_q;         // Compare and sync events
    wire [3:0]  evt_d;
    wire [3:0]  evt_set;       // Event strobes in bit order

    // Combined status views
    wire        sr_read;       // Status register being read
    wire        wr_set_en;     // Data phase of enable write
    wire        wr_set_dis;    // Data phase of disable write
    wire        wr_cmp1;       // Data phase of compare write
    reg  [31:0] status;        // Live status word
    reg  [31:0] rdata_d;       // Next read data
    reg         irq_d;         // Next interrupt level
    reg  [11:0] status_next;   // Flags as they stand after this edge

    // Address phase decode
    assign xfer_act = hsel & hready & htrans[`SSS_HTRANS_ACT];
    assign rd_take  = xfer_act & ~hwrite;
    assign wr_take  = xfer_act & hwrite;
    assign a_lo     = haddr[7:0];
    assign sr_read  = rd_take & addr_hit(a_lo, `SSS_OFF_STATUS);

    // Data phase write strobes
    assign wr_set_en  = wr_pend_q & addr_hit(wr_addr_q, `SSS_OFF_IRQ_SET);
    assign wr_set_dis = wr_pend_q & addr_hit(wr_addr_q, `SSS_OFF_IRQ_CLR);
    assign wr_cmp1    = wr_pend_q & addr_hit(wr_addr_q, `SSS_OFF_CMP1);

    // Write phase tracking
    always @*
    begin
        wr_pend_d = wr_pend_q;
        wr_addr_d = wr_addr_q;
        // A new address phase replaces the old once hready is high
        if (hready)
        begin
            wr_pend_d = wr_take;
            wr_addr_d = a_lo;
        end
    end

    // Mask and compare register updates
    always @*
    begin
        mask_d = mask_q;
        cmp1_d = cmp1_value;
        // Ones in the enable word set mask bits
        if (wr_set_en)
        begin
            mask_d = mask_q | hwdata[11:0];                 // [RL15]
        end
        // Ones in the disable word clear mask bits
        if (wr_set_dis)
        begin
            mask_d = mask_q & ~hwdata[11:0];                // [RL16]
        end
        // Only the low half word is stored
        if (wr_cmp1)
        begin
            cmp1_d = hwdata[15:0];                          // [RL17]
        end
    end

    // DMA count-done and overrun flags, set beats clear
    // Clears come first so that a set in the same cycle overrides them
    always @*
    begin
        tx_done_d = tx_done_q;
        rx_done_d = rx_done_q;
        ovr_d     = ovr_q;
        // Software wrote a transmit counter, done flag drops
        if (tx_cnt_written)
        begin
            tx_done_d = 1'h0;                               // [RL3]
        end
        // Transmit counter reached zero, done flag rises
        if (tx_cnt_hit_zero)
        begin
            tx_done_d = 1'h1;                               // [RL3]
        end
        // Software wrote a receive counter, done flag drops
        if (rx_cnt_written)
        begin
            rx_done_d = 1'h0;                               // [RL7]
        end
        // Receive counter reached zero, done flag rises
        if (rx_cnt_hit_zero)
        begin
            rx_done_d = 1'h1;                               // [RL7]
        end
        // Status read clears the overrun flag
        if (sr_read)
        begin
            ovr_d = 1'h0;                                   // [RL6]
        end
        // Word loaded while the previous one is unread
        if (rx_word_load & rx_holding_full)
        begin
            ovr_d = 1'h1;                                   // [RL6]
        end
    end

    // Compare and frame-sync event strobes
    assign evt_set[0] = compare_zero_hit;                   // [RL9]
    assign evt_set[1] = compare_one;                        // [RL10]
    assign evt_set[2] = tx_frame_sync_seen;                 // [RL11]
    assign evt_set[3] = rx_frame_sync_seen;                 // [RL12]

    // Read-to-clear event flags, a strobe in the read cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_evt
            assign evt_d[gi] = evt_set[gi] | (evt_q[gi] & ~sr_read);
        end
    endgenerate

    // Live status word assembly
    always @*
    begin
        status = `SSS_WORD_ZERO;
        // Transmit levels and the sticky count-done flag
        status[`SSS_BIT_TXHF]   = tx_holding_free;          // [RL1]
        status[`SSS_BIT_TXAS]   = tx_all_sent;              // [RL2]
        status[`SSS_BIT_TXDONE] = tx_done_q;
        status[`SSS_BIT_TXBZ]   = tx_cnt_is_zero & tx_next_cnt_is_zero; // [RL4]
        // Receive levels and the sticky overrun and count-done flags
        status[`SSS_BIT_RXHF]   = rx_holding_full;          // [RL5]
        status[`SSS_BIT_OVR]    = ovr_q;
        status[`SSS_BIT_RXDONE] = rx_done_q;
        status[`SSS_BIT_RXBZ]   = rx_cnt_is_zero & rx_next_cnt_is_zero; // [RL8]
        // Sticky events
        status[`SSS_BIT_CMP0]   = evt_q[0];
        status[`SSS_BIT_CMP1]   = evt_q[1];
        status[`SSS_BIT_TX_FSYNC] = evt_q[2];
        status[`SSS_BIT_RX_FSYNC] = evt_q[3];
        // Enable states
        status[`SSS_BIT_TX_ON]  = tx_enabled_state;         // [RL13]
        status[`SSS_BIT_RX_ON]  = rx_enabled_state;         // [RL14]
    end

    // Read data for the following data phase
    always @*
    begin
        rdata_d = `SSS_WORD_ZERO;
        // Unmapped offsets and writes return zero
        if (rd_take)
        begin
            if (addr_hit(a_lo, `SSS_OFF_CMP1))
            begin
                rdata_d[15:0] = cmp1_value;                 // [RL17]
            end
            else if (addr_hit(a_lo, `SSS_OFF_STATUS))
            begin
                rdata_d = status;
            end
            else if (addr_hit(a_lo, `SSS_OFF_MASK_RD))
            begin
                rdata_d[11:0] = mask_q;                     // [RL18]
            end
            else
            begin
                rdata_d = `SSS_WORD_ZERO;
            end
        end
    end

    // Interrupt level from flags as they will stand
    always @*
    begin
        status_next = status[11:0];
        // Sticky bits take their next values
        status_next[`SSS_BIT_TXDONE] = tx_done_d;
        status_next[`SSS_BIT_OVR]    = ovr_d;
        status_next[`SSS_BIT_RXDONE] = rx_done_d;
        status_next[11:8]            = evt_d;
        irq_d = |(status_next & mask_d);                    // [RL19]
    end

    // Bus response registers, zero wait states and always OKAY
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Idle bus: no data, ready, OKAY
            hrdata    <= `SSS_WORD_ZERO;
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end
        else
        begin
            // Read data for the data phase that follows
            hrdata    <= rdata_d;
            hreadyout <= 1'h1;
            hresp     <= 1'h0;
        end
    end

    // Write phase tracking registers
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // No write pending out of reset
            wr_pend_q <= 1'h0;
            wr_addr_q <= `SSS_ADDR_RST;
        end
        else
        begin
            // Follow the latest accepted address phase
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // Software-written registers: mask and compare value
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // All sources disabled, compare value cleared
            mask_q     <= `SSS_MASK_RST;                    // [RL20]
            cmp1_value <= `SSS_CMP1_RST;
        end
        else
        begin
            // Bus writes land in the data phase
            mask_q     <= mask_d;
            cmp1_value <= cmp1_d;
        end
    end

    // Sticky flags and the interrupt line
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            // Every event flag cleared, interrupt low
            tx_done_q <= `SSS_FLAG_RST;                     // [RL20]
            rx_done_q <= `SSS_FLAG_RST;
            ovr_q     <= `SSS_FLAG_RST;
            evt_q     <= `SSS_EVT_RST;
            irq       <= 1'h0;
        end
        else
        begin
            // Next values from the flag logic
            tx_done_q <= tx_done_d;
            rx_done_q <= rx_done_d;
            ovr_q     <= ovr_d;
            evt_q     <= evt_d;
            irq       <= irq_d;
        end
    end

endmodule // sss_top
`default_nettype wire

// *** bench/sss_checker.sv ***
// Port-level assertions for the serial status slice
`timescale 1ns/1ps
`default_nettype none
module sss_checker
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Bus side
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Status sources
    input wire logic        tx_holding_free,
    input wire logic        tx_all_sent,
    input wire logic        tx_cnt_is_zero,
    input wire logic        tx_next_cnt_is_zero,
    input wire logic        tx_cnt_hit_zero,
    input wire logic        tx_cnt_written,
    input wire logic        rx_holding_full,
    input wire logic        rx_word_load,
    input wire logic        compare_zero_hit,
    input wire logic        compare_one,
    // Outputs
    input wire logic [15:0] cmp1_value,
    input wire logic        irq
);
    // Address phase decodes
    wire logic        rd_st = hsel && hready && htrans[1] && !hwrite && haddr[7:2] == 6'h01;
    wire logic        wr_cmp = hsel && hready && htrans[1] && hwrite && haddr[7:2] == 6'h00;
    wire logic [15:0] wlo = hwdata[15:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_live_bits: assert property (rd_st |=> hrdata[0] == $past(tx_holding_free)
        && hrdata[1] == $past(tx_all_sent)) else $error("live transmit bits wrong");
    a_level_bits: assert property (rd_st |=> hrdata[4] == $past(rx_holding_full)
        && hrdata[3] == ($past(tx_cnt_is_zero) && $past(tx_next_cnt_is_zero)))
        else $error("level bits wrong");
    a_cmp0_latch: assert property (compare_zero_hit ##1 !rd_st ##1 rd_st |=> hrdata[8])
        else $error("compare zero flag not latched");
    a_read_clear: assert property ((rd_st && !compare_one) ##1 (!compare_one) [*2]
        ##1 rd_st |=> !hrdata[9]) else $error("compare one flag not cleared by read");
    a_txdone_set: assert property (tx_cnt_hit_zero ##1 !tx_cnt_written ##1 rd_st
        |=> hrdata[2]) else $error("tx count done not set");
    a_txdone_clr: assert property ((tx_cnt_written && !tx_cnt_hit_zero)
        ##1 !tx_cnt_hit_zero ##1 rd_st |=> !hrdata[2])
        else $error("tx count done not cleared");
    a_overrun_set: assert property ((rx_word_load && rx_holding_full) ##1 !rd_st ##1
        rd_st |=> hrdata[5]) else $error("overrun not set");
    a_cmp1_write: assert property (wr_cmp |=> ##1 cmp1_value == $past(wlo))
        else $error("compare value not written");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !irq
        && cmp1_value == 16'h0000) else $error("outputs not cleared by reset");
endmodule // sss_checker

bind sss_top sss_checker u_chk
(
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_holding_free(tx_holding_free),
    .tx_all_sent(tx_all_sent), .tx_cnt_is_zero(tx_cnt_is_zero),
    .tx_next_cnt_is_zero(tx_next_cnt_is_zero), .tx_cnt_hit_zero(tx_cnt_hit_zero),
    .tx_cnt_written(tx_cnt_written), .rx_holding_full(rx_holding_full),
    .rx_word_load(rx_word_load), .compare_zero_hit(compare_zero_hit),
    .compare_one(compare_one), .cmp1_value(cmp1_value), .irq(irq)
);
`default_nettype wire

// *** bench/sync_serial_status_irq_test.sv ***
// Directed testbench for the serial status slice
`timescale 1ns/1ps
`default_nettype none
module sync_serial_status_irq_test;
    logic             clk = 1'b0;
    logic             rst_n, hsel, hwrite;
    logic [31:0]      haddr, hwdata, rd;
    logic [1:0]       htrans;
    logic [8:0]       ev, lv;       // Event pulses and status levels
    wire logic [31:0] hrdata;
    wire logic [15:0] cmp1_value;
    wire logic        hreadyout, hresp, irq;
    int               err_total = 0;
    int               n_compared = 0;
    logic [8:0]       pats [5] = '{9'h1FF, 9'h0AA, 9'h155, 9'h018, 9'h180};

    // 25 MHz clock
    always #20 clk = ~clk;

    sss_top DUT
    (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .tx_holding_free(lv[0]), .tx_all_sent(lv[1]), .tx_enabled_state(lv[2]),
        .tx_cnt_hit_zero(ev[5]), .tx_cnt_is_zero(lv[3]), .tx_next_cnt_is_zero(lv[4]),
        .tx_cnt_written(ev[7]), .rx_holding_full(lv[5]), .rx_word_load(ev[4]),
        .rx_enabled_state(lv[6]), .rx_cnt_hit_zero(ev[6]), .rx_cnt_is_zero(lv[7]),
        .rx_next_cnt_is_zero(lv[8]), .rx_cnt_written(ev[8]),
        .compare_zero_hit(ev[0]), .compare_one(ev[1]), .tx_frame_sync_seen(ev[2]),
        .rx_frame_sync_seen(ev[3]), .cmp1_value(cmp1_value), .irq(irq)
    );

    // Level part of the status word
    function automatic [31:0] lvl_exp(input [8:0] l);
        lvl_exp = {14'h0000, l[6], l[2], 8'h00, l[8] & l[7], 2'h0, l[5], l[4] & l[3],
                   1'b0, l[1], l[0]};
    endfunction

    task chk(input [31:0] g, input [31:0] e);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One single AHB transfer, read data lands in rd
    task bus(input logic w, input [7:0] a, input [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // One-cycle event strobe
    task pulse(input [8:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 9'h000;
    endtask

    task t_regs;
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h00000000);
        bus(1'b1, 8'h00, 32'hFFFFA5C3);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0000A5C3);
        bus(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h00000000);
    endtask

    task t_levels;
        foreach (pats[i])
        begin
            @(posedge clk);
            lv <= pats[i];
            bus(1'b0, 8'h04, 32'h0);
            chk(rd, lvl_exp(pats[i]));
        end
        lv <= 9'h020;
    endtask

    task t_events;
        pulse(9'h07F);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000F74);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000054);
        pulse(9'h180);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000010);
        lv <= 9'h000;
        pulse(9'h010);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000000);
    endtask

    task t_irq;
        bus(1'b1, 8'h0C, 32'h00000FFF);
        pulse(9'h002);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, 8'h08, 32'h00000200);
        @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000200);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
    endtask

    task t_mask;
        bus(1'b1, 8'h08, 32'hFFFFFFFF);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h00000FFF);
        bus(1'b1, 8'h0C, 32'h000000A5);
        bus(1'b1, 8'h08, 32'h00000000);
        bus(1'b1, 8'h0C, 32'h00000000);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h00000F5A);
    endtask

    task t_reset;
        pulse(9'h00F);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h00000000);
        bus(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h00000000);
        chk({31'h0, irq}, 32'h0);
    endtask

    task final_report;
        if (err_total == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        ev = 9'h000;
        lv = 9'h000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_levels;
        t_events;
        t_irq;
        t_mask;
        t_reset;
        final_report;
    end

    // Watchdog against a stalled bus
    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report;
    end
endmodule // sync_serial_status_irq_test
`default_nettype wire
